/* File: hw/zcd_consts.svh */
// How it works
// - Analog sinks above threshold; sink indication raw
// - Level equals sink, inverted when polarity set
// - Rising edge sets flag when rise enabled
// - Falling edge sets flag when fall enabled
// - Interrupt needs flag plus all enables
// - Polarity toggle makes edge regardless of enable
// - Software clears flag; simultaneous set wins
// - Enable takes pin over; else normal control
// - Config bit clear means always active
// - Control bits reset zero; unused read zero
// - Detection keeps running during processor sleep
// - Level also offered to logic cells
// - Flag and enable at bit four
`ifndef ZCD_CONSTS_SVH
`define ZCD_CONSTS_SVH
`define ZCD_OFS_CONTROL 8'h00
`define ZCD_OFS_IRQ_ENABLE_3 8'h04
`define ZCD_OFS_IRQ_FLAG_3 8'h08
`define ZCD_OFS_GLOBAL 8'h0C
`define ZCD_BIT_EN 7
`define ZCD_BIT_LEVEL 5
`define ZCD_BIT_POL 4
`define ZCD_BIT_RISE 1
`define ZCD_BIT_FALL 0
`define ZCD_BIT_IRQ 4
`define ZCD_BIT_PERIPHERAL_IRQ_GLOBAL_ENABLE 0
`define ZCD_BIT_GIE 1
`define ZCD_CTRL_RESET 8'h00
`define ZCD_CTRL_WMASK 8'h93
`define ZCD_SYNC_STAGES 2
`endif

/* File: hw/zcd_pkg.sv */
package zcd_pkg;
  typedef enum logic [1:0] {
    ZCD_RESP_OKAY = 2'b00,
    ZCD_RESP_SLVERR = 2'b10
  } zcd_resp_t;
  typedef enum {
    ZCD_W_IDLE,
    ZCD_W_RESP
  } zcd_wstate_t;
endpackage : zcd_pkg

/* File: hw/zcd_sync.sv */
`timescale 1ns/1ns
// Two-flop synchroniser; first stage read only by second
module zcd_sync #(
  parameter int STAGES = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic async_in,
  output logic sync_out
);
  logic [STAGES-1:0] chain_ff;
  // Shift chain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chain_ff <= '0;
    end else begin
      chain_ff <= {chain_ff[STAGES-2:0], async_in};
    end
  end
  assign sync_out = chain_ff[STAGES-1];
endmodule : zcd_sync

/* File: hw/zcd_top.sv */
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "zcd_consts.svh"
module zcd_top
  import zcd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sink_active,
  input wire logic power_on_detector_disable,
  output logic detector_active,
  output logic pin_takeover,
  output logic zero_cross_signal,
  output logic irq
);
  logic sink_sync;
  logic en_ff;
  logic pol_ff;
  logic rise_ff;
  logic fall_ff;
  logic flag_ff;
  logic ie_ff;
  logic peripheral_irq_global_enable_ff;
  logic gie_ff;
  logic level_prev_ff;
  logic level;
  logic rise_evt;
  logic fall_evt;
  logic set_evt;
  logic aw_held_ff;
  logic w_held_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic do_write;
  logic wr_ctrl;
  logic wr_ie;
  logic wr_flag;
  logic wr_glob;
  logic [7:0] wbyte;
  logic [7:0] ctrl_rd;

  // Synchronise the analog sink indication
  zcd_sync #(
    .STAGES(`ZCD_SYNC_STAGES)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(sink_active),
    .sync_out(sink_sync)
  );

  // Polarity applied after sync, so a toggle is an edge too
  assign level = sink_sync ^ pol_ff;
  assign zero_cross_signal = level;

  // Previous level for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_prev_ff <= 1'b0;
    end else begin
      level_prev_ff <= level;
    end
  end

  // Edge detectors, independent of enable and sleep
  assign rise_evt = level & ~level_prev_ff & rise_ff;
  assign fall_evt = ~level & level_prev_ff & fall_ff;
  assign set_evt = rise_evt | fall_evt;

  // Detector runs from power-on unless the config bit is set
  assign detector_active = ~power_on_detector_disable | en_ff;
  assign pin_takeover = detector_active;

  // Interrupt output gated by all enables
  assign irq = flag_ff & ie_ff & peripheral_irq_global_enable_ff & gie_ff;

  // Write channel capture: address and data in either order
  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_held_ff & ~bvalid_ff;
  assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wbyte = wstrb_ff[0] ? wdata_ff[7:0] : 8'h00;
  assign wr_ctrl = do_write && wstrb_ff[0] && awaddr_ff == `ZCD_OFS_CONTROL;
  assign wr_ie = do_write && wstrb_ff[0] && awaddr_ff == `ZCD_OFS_IRQ_ENABLE_3;
  assign wr_flag = do_write && wstrb_ff[0] && awaddr_ff == `ZCD_OFS_IRQ_FLAG_3;
  assign wr_glob = do_write && wstrb_ff[0] && awaddr_ff == `ZCD_OFS_GLOBAL;

  // Hold address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  // Hold data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  // Write response; unmapped address answers SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= ZCD_RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (awaddr_ff == `ZCD_OFS_CONTROL || awaddr_ff == `ZCD_OFS_IRQ_ENABLE_3 ||
                   awaddr_ff == `ZCD_OFS_IRQ_FLAG_3 || awaddr_ff == `ZCD_OFS_GLOBAL) ?
                  ZCD_RESP_OKAY : ZCD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Control register bits, reset to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_ff <= 1'b0;
      pol_ff <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else if (wr_ctrl) begin
      en_ff <= wbyte[`ZCD_BIT_EN];
      pol_ff <= wbyte[`ZCD_BIT_POL];
      rise_ff <= wbyte[`ZCD_BIT_RISE];
      fall_ff <= wbyte[`ZCD_BIT_FALL];
    end
  end

  // Enables: zero-cross enable at bit 4, global enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ie_ff <= 1'b0;
      peripheral_irq_global_enable_ff <= 1'b0;
      gie_ff <= 1'b0;
    end else begin
      if (wr_ie) begin
        ie_ff <= wbyte[`ZCD_BIT_IRQ];
      end
      if (wr_glob) begin
        peripheral_irq_global_enable_ff <= wbyte[`ZCD_BIT_PERIPHERAL_IRQ_GLOBAL_ENABLE];
        gie_ff <= wbyte[`ZCD_BIT_GIE];
      end
    end
  end

  // Sticky flag, write one to clear; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_ff <= 1'b0;
    end else if (set_evt) begin
      flag_ff <= 1'b1;
    end else if (wr_flag && wbyte[`ZCD_BIT_IRQ]) begin
      flag_ff <= 1'b0;
    end
  end

  // Control readback; unimplemented bits read zero
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`ZCD_BIT_EN] = en_ff;
    ctrl_rd[`ZCD_BIT_LEVEL] = level;
    ctrl_rd[`ZCD_BIT_POL] = pol_ff;
    ctrl_rd[`ZCD_BIT_RISE] = rise_ff;
    ctrl_rd[`ZCD_BIT_FALL] = fall_ff;
  end

  // Read channel: one read at a time, one-cycle answer
  assign s_axi_arready = ~rvalid_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= ZCD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= ZCD_RESP_OKAY;
      case (s_axi_araddr)
        `ZCD_OFS_CONTROL: begin
          rdata_ff <= {24'h000000, ctrl_rd};
        end
        `ZCD_OFS_IRQ_ENABLE_3: begin
          rdata_ff <= {27'h0000000, ie_ff, 4'h0};
        end
        `ZCD_OFS_IRQ_FLAG_3: begin
          rdata_ff <= {27'h0000000, flag_ff, 4'h0};
        end
        `ZCD_OFS_GLOBAL: begin
          rdata_ff <= {30'h00000000, gie_ff, peripheral_irq_global_enable_ff};
        end
        default: begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= ZCD_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Rising level with rise enabled sets flag next cycle
  a_rise_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (level && !level_prev_ff && rise_ff) |=> flag_ff) else $error("rise did not set flag");
  // Falling level with fall enabled sets flag
  a_fall_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (!level && level_prev_ff && fall_ff) |=> flag_ff) else $error("fall did not set flag");
  // No event means flag never rises
  a_flag_needs_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    (!flag_ff && !set_evt) |=> !flag_ff) else $error("flag set without edge");
  // Set beats clear in the same cycle
  a_set_beats_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (set_evt && wr_flag) |=> flag_ff) else $error("clear won over set");
  // Interrupt only with all enables
  a_irq_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    irq |-> (flag_ff && ie_ff && peripheral_irq_global_enable_ff && gie_ff)) else $error("irq without enables");
  // Level follows synchronised sink and polarity
  a_level_polarity: assert property (@(posedge aclk) disable iff (!aresetn)
    zero_cross_signal == ($past(u_sync.chain_ff[0]) ^ pol_ff) || $changed(pol_ff) || $rose(aresetn))
    else $error("level mismatch");
  // Config clear keeps detector active
  a_poweron_active: assert property (@(posedge aclk) disable iff (!aresetn)
    !power_on_detector_disable |-> detector_active) else $error("detector inactive");
  // Takeover follows enable when config set
  a_takeover_en: assert property (@(posedge aclk) disable iff (!aresetn)
    power_on_detector_disable |-> (pin_takeover == en_ff)) else $error("takeover mismatch");
  // Control bits zero after reset
  a_reset_zero: assert property (@(posedge aclk)
    $rose(aresetn) |-> (!en_ff && !pol_ff && !rise_ff && !fall_ff)) else $error("reset value wrong");
  // Flag placed at bit four of a flag register read
  a_flag_bit4: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == `ZCD_OFS_IRQ_FLAG_3) |=> (s_axi_rdata[4] == $past(flag_ff)))
    else $error("flag bit position");

  // Rising level with rise disabled leaves a clear flag clear
  a_rise_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    (level && !level_prev_ff && !rise_ff && !flag_ff) |=> !flag_ff) else $error("rise set flag when off");

  // Falling level with fall disabled leaves a clear flag clear
  a_fall_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    (!level && level_prev_ff && !fall_ff && !flag_ff) |=> !flag_ff) else $error("fall set flag when off");

  // Clearing write with no edge empties the flag
  a_clear_works: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_flag && wbyte[`ZCD_BIT_IRQ] && !set_evt) |=> !flag_ff) else $error("flag not cleared");

  // Flag stays set until software writes the flag register
  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (flag_ff && !wr_flag) |=> flag_ff) else $error("flag lost without clear");

  // Flag with every enable raises the interrupt
  a_irq_raised: assert property (@(posedge aclk) disable iff (!aresetn)
    (flag_ff && ie_ff && peripheral_irq_global_enable_ff && gie_ff) |-> irq) else $error("irq missing");

  // Polarity change with a steady sink is a level edge
  a_pol_makes_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    ($changed(pol_ff) && $stable(sink_sync)) |-> (level != level_prev_ff)) else $error("polarity gave no edge");

  // Control write loads enable and polarity
  a_ctrl_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctrl |=> (en_ff == $past(wbyte[`ZCD_BIT_EN]) && pol_ff == $past(wbyte[`ZCD_BIT_POL])))
    else $error("control write lost");

  // Control write loads both edge enables
  a_edge_en_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctrl |=> (rise_ff == $past(wbyte[`ZCD_BIT_RISE]) && fall_ff == $past(wbyte[`ZCD_BIT_FALL])))
    else $error("edge enable write lost");

  // Unimplemented control bits read zero
  a_ctrl_unused: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == `ZCD_OFS_CONTROL) |=>
    (s_axi_rdata[31:8] == 24'h000000 && !s_axi_rdata[6] && s_axi_rdata[3:2] == 2'b00))
    else $error("unused control bit set");

  // Level bit of a control read is the level at the read
  a_level_readback: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == `ZCD_OFS_CONTROL) |=>
    (s_axi_rdata[`ZCD_BIT_LEVEL] == $past(level))) else $error("level readback wrong");

  // Enable read shows the zero-cross enable at bit four
  a_ie_bit4: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == `ZCD_OFS_IRQ_ENABLE_3) |=>
    (s_axi_rdata[`ZCD_BIT_IRQ] == $past(ie_ff))) else $error("enable bit position");

  // Enable write takes bit four
  a_ie_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ie |=> (ie_ff == $past(wbyte[`ZCD_BIT_IRQ]))) else $error("enable write lost");

  // Flag, enable and interrupt clear after reset
  a_irq_reset: assert property (@(posedge aclk)
    $rose(aresetn) |-> (!flag_ff && !ie_ff && !irq)) else $error("irq state after reset");

  // Config set and enable clear give the pin back
  a_takeover_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (power_on_detector_disable && !en_ff) |-> !pin_takeover) else $error("pin kept without enable");

  // Synchronised sink is the input two cycles back
  a_sync_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(sink_sync) |-> (sink_sync == $past(sink_active, 2))) else $error("sync latency wrong");

  // Write answered the cycle after both halves are held
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid) else $error("write not answered");

  // Write response stands until taken
  a_bvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid) else $error("write response dropped");

  // Read answered on the next cycle
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid) else $error("read not answered");

  // Read data stands until taken
  a_rvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata))) else $error("read data dropped");

endmodule : zcd_top

/* File: tb/tb_zero_cross_detect_logic.sv */
`timescale 1ns/1ns
`include "zcd_consts.svh"
module tb_zero_cross_detect_logic
  import zcd_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sink_active, power_on_detector_disable;
  logic detector_active, pin_takeover, zero_cross_signal, irq, pin_above;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int miscompares = 0;
  int n_tests = 0;

  zcd_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sink_active,
    .power_on_detector_disable, .detector_active, .pin_takeover, .zero_cross_signal, .irq);
  zcd_analog_model model (.pin_above, .sink_active);

  // Clock at 125 MHz
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Write: offer address and data together, release each when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_t, w_t, b_t;
    logic [1:0] r;
    b_t = 1'b0;
    r = 2'b00;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    chk("bresp", {30'h0, r}, {30'h0, ZCD_RESP_OKAY});
  endtask : wr

  // Read and compare data and response
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic a_t, v_t;
    logic [31:0] d;
    logic [1:0] r;
    v_t = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!v_t) begin
      @(negedge aclk);
      a_t = s_axi_arvalid && s_axi_arready;
      v_t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (a_t) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    chk(nm, d, exp);
    chk({nm, " resp"}, {30'h0, r}, {30'h0, er});
  endtask : rd

  task automatic pin(input logic v);
    pin_above <= v;
    repeat (5) @(posedge aclk);
  endtask : pin

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // Cut a hang short
  initial begin
    repeat (5000) @(posedge aclk);
    miscompares++;
    finish_test();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {pin_above, power_on_detector_disable} = 2'b00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values and an unmapped place
    rd("ctrl", `ZCD_OFS_CONTROL, 32'h0, ZCD_RESP_OKAY);
    rd("flag", `ZCD_OFS_IRQ_FLAG_3, 32'h0, ZCD_RESP_OKAY);
    rd("ien", `ZCD_OFS_IRQ_ENABLE_3, 32'h0, ZCD_RESP_OKAY);
    rd("unmapped", 8'h10, 32'h0, ZCD_RESP_SLVERR);
    chk("active", {31'h0, detector_active}, 32'h1);
    $display("test reset done");
    // Polarity toggle raises the level with every control bit set
    wr(`ZCD_OFS_CONTROL, 8'hFF);
    rd("ctrl", `ZCD_OFS_CONTROL, 32'hB3, ZCD_RESP_OKAY);
    rd("flag", `ZCD_OFS_IRQ_FLAG_3, 32'h10, ZCD_RESP_OKAY);
    chk("signal", {31'h0, zero_cross_signal}, 32'h1);
    wr(`ZCD_OFS_IRQ_FLAG_3, 8'h10);
    rd("flag", `ZCD_OFS_IRQ_FLAG_3, 32'h0, ZCD_RESP_OKAY);
    $display("test polarity done");
    // Edges from the analog stage under each enable
    wr(`ZCD_OFS_CONTROL, 8'h02);
    rd("flag", `ZCD_OFS_IRQ_FLAG_3, 32'h0, ZCD_RESP_OKAY);
    pin(1'b1);
    rd("flag", `ZCD_OFS_IRQ_FLAG_3, 32'h10, ZCD_RESP_OKAY);
    rd("ctrl", `ZCD_OFS_CONTROL, 32'h22, ZCD_RESP_OKAY);
    wr(`ZCD_OFS_IRQ_FLAG_3, 8'h10);
    wr(`ZCD_OFS_CONTROL, 8'h01);
    pin(1'b0);
    rd("flag", `ZCD_OFS_IRQ_FLAG_3, 32'h10, ZCD_RESP_OKAY);
    wr(`ZCD_OFS_IRQ_FLAG_3, 8'h10);
    pin(1'b1);
    rd("flag", `ZCD_OFS_IRQ_FLAG_3, 32'h0, ZCD_RESP_OKAY);
    pin(1'b0);
    $display("test edges done");
    // Interrupt needs the flag and every enable
    wr(`ZCD_OFS_IRQ_ENABLE_3, 8'h10);
    wr(`ZCD_OFS_GLOBAL, 8'h01);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(`ZCD_OFS_GLOBAL, 8'h03);
    chk("irq", {31'h0, irq}, 32'h1);
    rd("glob", `ZCD_OFS_GLOBAL, 32'h3, ZCD_RESP_OKAY);
    wr(`ZCD_OFS_IRQ_ENABLE_3, 8'h00);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(`ZCD_OFS_IRQ_ENABLE_3, 8'h10);
    wr(`ZCD_OFS_IRQ_FLAG_3, 8'h10);
    chk("irq", {31'h0, irq}, 32'h0);
    // Rising edge lands in the cycle of the clearing write
    wr(`ZCD_OFS_CONTROL, 8'h03);
    pin_above <= 1'b1;
    @(posedge aclk);
    wr(`ZCD_OFS_IRQ_FLAG_3, 8'h10);
    rd("flag", `ZCD_OFS_IRQ_FLAG_3, 32'h10, ZCD_RESP_OKAY);
    $display("test irq done");
    // Enable bit matters only with the power-on disable set
    power_on_detector_disable <= 1'b1;
    @(posedge aclk);
    chk("active", {31'h0, detector_active}, 32'h0);
    wr(`ZCD_OFS_CONTROL, 8'h80);
    chk("takeover", {31'h0, pin_takeover}, 32'h1);
    wr(`ZCD_OFS_CONTROL, 8'h00);
    chk("takeover", {31'h0, pin_takeover}, 32'h0);
    $display("test enable done");
    finish_test();
  end
endmodule : tb_zero_cross_detect_logic

/* File: tb/zcd_analog_model.sv */
`timescale 1ns/1ns
// Analog current stage seen from the digital side
module zcd_analog_model (
  input wire logic pin_above,
  output logic sink_active
);
  // Sink while the pin sits above the threshold, source below it
  assign sink_active = pin_above;
endmodule : zcd_analog_model
